// *** pkg/comap_map.svh ***
/*
  register offsets, field positions and reset values of the
  contact output mapper. assumes inclusion by bare name from the package; rtl sees the macros through it.
*/
`ifndef COMAP_MAP_SVH
`define COMAP_MAP_SVH

// ==========================================================================
// register byte offsets
`define COMAP_OFF_CFG0     12'h000
`define COMAP_OFF_CFG1     12'h004
`define COMAP_OFF_CFG2     12'h008
`define COMAP_OFF_ALMSEL   12'h00C
`define COMAP_OFF_STATUS   12'h010

// ==========================================================================
// config register fields: source select [3:0], polarity bit 8
`define COMAP_SRC_LSB      0
`define COMAP_SRC_MSB      3
`define COMAP_POL_BIT      8

// ==========================================================================
// status register fields
`define COMAP_ST_OUT_LSB   0
`define COMAP_ST_REM_BIT   4
`define COMAP_ST_PWR_BIT   5

// ==========================================================================
// reset values: source code | polarity << 8
`define COMAP_RST_CFG0     32'h0000_0001
`define COMAP_RST_CFG1     32'h0000_0002
`define COMAP_RST_CFG2     32'h0000_0106
`define COMAP_RST_ALMSEL   32'h0000_0000

`endif

// *** pkg/comap_pkg.sv ***
/*
  types of the contact output mapper: source function codes.
  assumes comap_map.svh sits on the include path.
*/
package comap_pkg;
  `include "comap_map.svh"

  // ========================================================================
  // source function codes
  typedef enum logic [3:0] {
    COMAP_SRC_NONE    = 4'h0,
    COMAP_SRC_RUN     = 4'h1,
    COMAP_SRC_REMOTE  = 4'h2,
    COMAP_SRC_TREADY  = 4'h3,
    COMAP_SRC_HALTALM = 4'h4,
    COMAP_SRC_RUNALM  = 4'h5,
    COMAP_SRC_ANYALM  = 4'h6,
    COMAP_SRC_SELALM  = 4'h7,
    COMAP_SRC_DSTART  = 4'h8,
    COMAP_SRC_DSTOP   = 4'h9,
    COMAP_SRC_RESTART = 4'hA,
    COMAP_SRC_FREEZE  = 4'hB,
    COMAP_SRC_INPUT_ONE_PASSTHRU    = 4'hC,
    COMAP_SRC_INPUT_TWO_PASSTHRU    = 4'hD,
    COMAP_SRC_FILL    = 4'hE
  } comap_src_e;
endpackage

// *** src/comap_contact_output_mapper.sv ***
/*
  contact output mapper: three relay contact outputs, each a selectable
  source condition with normally-open or normally-closed polarity, set up
  over an ahb-lite slave. assumes condition inputs from the same clock
  domain except the contact inputs, which come from pins.
*/
// The AHB-Lite interface to the registers and the register addresses were left to the implementer.
// Function
// - three independent contact outputs follow conditions
// - source and polarity per output configurable
// - defaults run NO, remote NO, alarm NC
// - unpowered: all contacts open (code holds them unchanged while clkEn is low)
// - no-function: NO open, NC closed
// - running source asserts while operating
// - remote source follows contact remote mode
// - temperature ready source asserts when ready
// - halting alarm source asserts on stopping alarm
// - running alarm source asserts on continuing alarm
// - any alarm source asserts on alarm
// - chosen alarm source asserts on selected alarm
// - delayed start source asserts when timer set
// - delayed stop source asserts when timer set
// - restart source asserts when recovery enabled
// - freeze source asserts when antifreeze enabled
// - passthrough NO copies contact input
// - passthrough NC inverts contact input
// - filling source asserts during auto filling
// - remote contact input drives remote mode
`timescale 1ns/1ps

module comap_contact_output_mapper
  import comap_pkg::*;
#(
  parameter int NUM_OUT   = 3,
  parameter int ALARM_NUM = 64
) (
  input  wire logic                 clk,
  input  wire logic                 reset,
  input  wire logic                 clkEn,
  // ahb-lite slave
  input  wire logic                 hsel,
  input  wire logic [11:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic      [31:0]          hrdata,
  output logic                      hreadyout,
  output logic                      hresp,
  // product condition inputs, same clock domain
  input  wire logic                 powerGood,
  input  wire logic                 running,
  input  wire logic                 remoteInputMomentary,
  input  wire logic                 tempReady,
  input  wire logic                 haltingFaultSrc,
  input  wire logic                 runningFault,
  input  wire logic                 anyFaultSrc,
  input  wire logic [ALARM_NUM-1:0] alarmActive,
  input  wire logic                 delayedStartSrc,
  input  wire logic                 delayedStopSrc,
  input  wire logic                 restartEnabled,
  input  wire logic                 freezeEnabled,
  input  wire logic                 autoFilling,
  // contact inputs from pins
  input  wire logic                 contactIn1,
  input  wire logic                 contactIn2,
  input  wire logic                 remoteOnInput2,
  // relay drive, 1 = contact closed
  output logic [NUM_OUT-1:0]        contactClosed,
  output logic                      contactRemoteMode
);

  // ========================================================================
  // elaboration checks
  initial begin
    if (NUM_OUT != 3) begin
      $error("comap: exactly three contact outputs are supported");
    end
    if (ALARM_NUM < 2 || ALARM_NUM > 256) begin
      $error("comap: alarm count must lie in 2..256");
    end
  end

  localparam int SELW = $clog2(ALARM_NUM);

  // ========================================================================
  // pin synchronisers: three stages, change counts when 2nd and 3rd agree
  logic [2:0] in1Sync;
  logic [2:0] in2Sync;
  logic       in1Clean;
  logic       in2Clean;

  // shift contact inputs through three flops
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      in1Sync <= 3'h0;
      in2Sync <= 3'h0;
    end else if (clkEn) begin
      in1Sync <= {in1Sync[1:0], contactIn1};
      in2Sync <= {in2Sync[1:0], contactIn2};
    end
  end

  // debounced levels update only when last two stages agree
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      in1Clean <= 1'b0;
      in2Clean <= 1'b0;
    end else if (clkEn) begin
      if (in1Sync[1] == in1Sync[2]) begin
        in1Clean <= in1Sync[2];
      end
      if (in2Sync[1] == in2Sync[2]) begin
        in2Clean <= in2Sync[2];
      end
    end
  end

  // ========================================================================
  // contact remote mode
  logic remoteRequest;
  logic remoteRequestPrev;
  assign remoteRequest = in2Clean & remoteOnInput2;

  // alternate follows level, momentary toggles on input release
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      contactRemoteMode <= 1'b0;
      remoteRequestPrev <= 1'b0;
    end else if (clkEn) begin
      remoteRequestPrev <= remoteRequest;
      if (!remoteOnInput2) begin
        contactRemoteMode <= 1'b0;
      end else if (!remoteInputMomentary) begin
        contactRemoteMode <= remoteRequest;
      end else if (remoteRequestPrev && !remoteRequest) begin
        contactRemoteMode <= ~contactRemoteMode;
      end
    end
  end

  // ========================================================================
  // ahb-lite register bus
  logic [31:0]     cfg [NUM_OUT];
  logic [SELW-1:0] alarmSel;
  logic            wrPend;
  logic [11:0]     wrAddr;
  logic            rdPend;
  logic [11:0]     rdAddr;
  logic            addrPhase;
  assign addrPhase = hsel & hready & htrans[1];

  // capture address phase; zero wait states
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wrPend <= 1'b0;
      rdPend <= 1'b0;
      wrAddr <= 12'h000;
      rdAddr <= 12'h000;
    end else if (clkEn) begin
      wrPend <= addrPhase & hwrite;
      rdPend <= addrPhase & ~hwrite;
      if (addrPhase) begin
        wrAddr <= haddr;
        rdAddr <= haddr;
      end
    end
  end

  // configuration writes in the data phase
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cfg[0]   <= `COMAP_RST_CFG0;
      cfg[1]   <= `COMAP_RST_CFG1;
      cfg[2]   <= `COMAP_RST_CFG2;
      alarmSel <= SELW'(`COMAP_RST_ALMSEL);
    end else if (clkEn && wrPend) begin
      unique case (wrAddr)
        `COMAP_OFF_CFG0:   cfg[0]   <= hwdata;
        `COMAP_OFF_CFG1:   cfg[1]   <= hwdata;
        `COMAP_OFF_CFG2:   cfg[2]   <= hwdata;
        `COMAP_OFF_ALMSEL: alarmSel <= hwdata[SELW-1:0];
        default: ;
      endcase
    end
  end

  // read mux, reserved bits and unmapped addresses read zero
  logic [31:0] next_hrdata;
  always_comb begin
    next_hrdata = 32'h0000_0000;
    unique case (haddr)
      `COMAP_OFF_CFG0:   next_hrdata = cfg[0] & 32'h0000_010F;
      `COMAP_OFF_CFG1:   next_hrdata = cfg[1] & 32'h0000_010F;
      `COMAP_OFF_CFG2:   next_hrdata = cfg[2] & 32'h0000_010F;
      `COMAP_OFF_ALMSEL: next_hrdata = 32'(alarmSel);
      `COMAP_OFF_STATUS: begin
        next_hrdata[`COMAP_ST_OUT_LSB +: 3] = contactClosed;
        next_hrdata[`COMAP_ST_REM_BIT]      = contactRemoteMode;
        next_hrdata[`COMAP_ST_PWR_BIT]      = powerGood;
      end
      default: next_hrdata = 32'h0000_0000;
    endcase
  end

  // read data registered at the address phase edge
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      hrdata <= 32'h0000_0000;
    end else if (clkEn && addrPhase && !hwrite) begin
      hrdata <= next_hrdata;
    end
  end

  // always ready, always okay
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else if (clkEn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // ========================================================================
  // per output source mux, polarity and relay register
  logic selectedAlarm;
  assign selectedAlarm = alarmActive[alarmSel];

  genvar g;
  generate
    for (g = 0; g < NUM_OUT; g++) begin : gOut
      comap_src_e src;
      logic       polNc;
      logic       cond;
      assign src   = comap_src_e'(cfg[g][`COMAP_SRC_MSB:`COMAP_SRC_LSB]);
      assign polNc = cfg[g][`COMAP_POL_BIT];

      // select source condition
      always_comb begin
        cond = 1'b0;
        unique case (src)
          COMAP_SRC_NONE:    cond = 1'b0;
          COMAP_SRC_RUN:     cond = running;
          COMAP_SRC_REMOTE:  cond = contactRemoteMode;
          COMAP_SRC_TREADY:  cond = tempReady;
          COMAP_SRC_HALTALM: cond = haltingFaultSrc;
          COMAP_SRC_RUNALM:  cond = runningFault;
          COMAP_SRC_ANYALM:  cond = anyFaultSrc;
          COMAP_SRC_SELALM:  cond = selectedAlarm;
          COMAP_SRC_DSTART:  cond = delayedStartSrc;
          COMAP_SRC_DSTOP:   cond = delayedStopSrc;
          COMAP_SRC_RESTART: cond = restartEnabled;
          COMAP_SRC_FREEZE:  cond = freezeEnabled;
          COMAP_SRC_INPUT_ONE_PASSTHRU:    cond = in1Clean;
          COMAP_SRC_INPUT_TWO_PASSTHRU:    cond = in2Clean;
          COMAP_SRC_FILL:    cond = autoFilling;
          default:           cond = 1'b0;               // code 4'hF unused
        endcase
      end

      // relay drive: condition xor polarity, forced open without power on clocks with clkEn high
      always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
          contactClosed[g] <= 1'b0;
        end else if (clkEn) begin
          contactClosed[g] <= powerGood & (cond ^ polNc);
        end
      end
    end
  endgenerate

endmodule // comap_contact_output_mapper

// *** bench/comap_contact_sensor.sv ***
/* customer equipment model: senses the three relay contacts.
   assumes contactClosed high means a closed contact. */
`timescale 1ns/1ps
module comap_contact_sensor (
  input  wire logic       clk,
  input  wire logic [2:0] contactClosed,
  output logic      [2:0] sensed
);
  // one sample per clock of each contact
  always_ff @(posedge clk) begin
    sensed <= contactClosed;
  end
endmodule // comap_contact_sensor

// *** bench/comap_checker_assertions.sv ***
/* port checker of the contact output mapper.
   assumes binding onto comap_contact_output_mapper. */
`timescale 1ns/1ps
module comap_checker #(
  parameter int NUM_OUT = 3
) (
  input wire logic               clk,
  input wire logic               reset,
  input wire logic               clkEn,
  input wire logic               hsel,
  input wire logic [1:0]         htrans,
  input wire logic               hwrite,
  input wire logic               hready,
  input wire logic               hreadyout,
  input wire logic               hresp,
  input wire logic               powerGood,
  input wire logic               running,
  input wire logic               anyFaultSrc,
  input wire logic               remoteOnInput2,
  input wire logic [NUM_OUT-1:0] contactClosed,
  input wire logic               contactRemoteMode
);
  // ==========================================================================
  // clean: no bus write to any address seen since reset
  logic clean;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) clean <= 1'b1;
    else if (clkEn && hsel && hready && htrans[1] && hwrite) clean <= 1'b0;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  sequence sLive; clkEn && powerGood && clean && !$past(reset); endsequence
  sequence sRunRise; (sLive and !running) ##1 (sLive and running); endsequence
  AST_UNPOWERED: assert property (clkEn && !powerGood |=> contactClosed == '0)
    else $error("contact closed while unpowered");
  AST_RUN_DEFAULT: assert property (sLive |=> contactClosed[0] == $past(running))
    else $error("output one does not follow running");
  AST_ALM_DEFAULT: assert property (sLive |=> contactClosed[2] == !$past(anyFaultSrc))
    else $error("output three does not invert alarm");
  AST_RUN_RISE: assert property (sRunRise |=> $rose(contactClosed[0]))
    else $error("output one missed running rise");
  AST_FROZEN: assert property (!clkEn |=> $stable(contactClosed))
    else $error("contacts moved while clock enable low");
  AST_LOCAL: assert property (clkEn && !remoteOnInput2 && !$past(reset) |=> !contactRemoteMode)
    else $error("remote mode without remote input");
  AST_READY: assert property (hreadyout)
    else $error("bus stalled");
  AST_OKAY: assert property (hresp == 1'b0)
    else $error("bus error response");
endmodule // comap_checker

bind comap_contact_output_mapper comap_checker #(.NUM_OUT(NUM_OUT)) comap_checker_i (
  .clk, .reset, .clkEn, .hsel, .htrans, .hwrite, .hready, .hreadyout, .hresp, .powerGood,
  .running, .anyFaultSrc, .remoteOnInput2, .contactClosed, .contactRemoteMode);

// *** bench/comap_contact_output_mapper_tb.sv ***
/* self-checking bench of the contact output mapper.
   assumes design, package, sensor model and checker compile first. */
`timescale 1ns/1ps
module comap_contact_output_mapper_tb;
  import comap_pkg::*;
  logic clk = 0, reset = 1, clkEn = 1, hsel = 0, hwrite = 0, powerGood = 1;
  logic [11:0] haddr = '0;
  logic [1:0]  htrans = '0;
  logic [2:0]  hsize = 3'h2, cc, sn;
  logic [31:0] hwdata = '0, hrdata, rdv, r, v;
  logic [15:0] c = '0, m;
  logic        hreadyout, hresp, remMode;
  logic [31:0] q[$];
  int          kq[$], k, n_mismatch = 0, checks = 0, cyc = 0;
  event        go;
  always #20 clk = ~clk;
  comap_contact_output_mapper comap_contact_output_mapper_i (
    .clk(clk), .reset(reset), .clkEn(clkEn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .powerGood(powerGood), .running(c[1]),
    .remoteInputMomentary(c[0]), .tempReady(c[3]), .haltingFaultSrc(c[4]),
    .runningFault(c[5]), .anyFaultSrc(c[6]), .alarmActive({c[7], 63'h0}),
    .delayedStartSrc(c[8]), .delayedStopSrc(c[9]), .restartEnabled(c[10]),
    .freezeEnabled(c[11]), .autoFilling(c[14]), .contactIn1(c[12]), .contactIn2(c[13]),
    .remoteOnInput2(c[2]), .contactClosed(cc), .contactRemoteMode(remMode));
  comap_contact_sensor comap_contact_sensor_i (.clk(clk), .contactClosed(cc), .sensed(sn));
  // ==========================================================================
  // verdict and timeout
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      report_and_stop();
    end
  end
  // monitor: oldest note against what is seen
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  always begin
    @(go);
    k = kq.pop_front();
    v = q.pop_front();
    chk(k == 0 ? "hrdata" : "contacts", k == 0 ? rdv : k == 1 ? 32'(sn) : 32'(sn[k-2]), v);
  end
  task automatic note(input int kind, input logic [31:0] exp);
    kq.push_back(kind);
    q.push_back(exp);
    -> go;
  endtask
  // single ahb-lite transfer, entered right after a rising edge
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
    hsel <= 1; haddr <= a; htrans <= 2'h2; hwrite <= wr;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 0; htrans <= 2'h0; hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rdv = hrdata;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    bus(0, a, 32'h0);
    note(0, exp);
  endtask
  task automatic look(input int kind, input logic [31:0] exp);
    repeat (8) @(posedge clk);
    note(kind, exp);
  endtask
  // ==========================================================================
  // main sequence
  initial begin
    r = $urandom(32'hb241);
    repeat (10) @(posedge clk);
    reset <= 0;
    @(posedge clk);
    rd(12'h000, 32'h0000_0001);
    rd(12'h004, 32'h0000_0002);
    rd(12'h008, 32'h0000_0106);
    rd(12'h00C, 32'h0000_0000);
    rd(12'h020, 32'h0000_0000);
    rd(12'h010, 32'h0000_0024);
    look(1, 32'h4);
    c <= 16'h0002;
    look(1, 32'h5);
    clkEn <= 0; powerGood <= 0; c <= 16'h0;
    look(1, 32'h5);
    clkEn <= 1;
    look(1, 32'h0);
    powerGood <= 1;
    look(1, 32'h4);
    $display("test defaults and power done");
    bus(1, 12'h00C, 32'h0000_003F);
    for (int s = 0; s < 32; s++) begin
      r = $urandom;
      m = r[15:0] & 16'h7FFA;
      c <= m;
      bus(1, 12'(4 * (s % 3)), 32'((s >> 1) | (s[0] << 8)));
      look(s % 3 + 2, 32'(m[s >> 1] ^ s[0]));
    end
    $display("test sources done");
    bus(1, 12'h004, 32'h0000_0002);
    c <= 16'h2004;
    look(3, 32'h1);
    c <= 16'h0004;
    look(3, 32'h0);
    c <= 16'h2000;
    look(3, 32'h0);
    c <= 16'h2005;
    look(3, 32'h0);
    c <= 16'h0005;
    look(3, 32'h1);
    $display("test remote done");
    report_and_stop();
  end
endmodule // comap_contact_output_mapper_tb
